/* hdl/tssr_step_reporter.sv */
// Target sequence engine reporting step code and interrupt cause
//
// How it works
// - Selection without ATN completes: step 2, 01/11.
// - Command parity error there: step 1, 01/11.
// - Selection loads bus ID then null message.
// - Short ATN selection completes: step 2, 02/12.
// - Short ATN held after message: step 0, 12.
// - Message parity or bad identify: step 0.
// - Extended three messages plus CDB: step 6.
// - Extended later message parity error: step 4, 02.
// - Extended ATN after third message: step 4, 12.
// - Extended command parity after three: step 5.
// - Extended ATN dropped, CDB done: step 2.
// - Extended command parity after one: step 1.
// - Receive command completes: step 2, 08/18.
// - Receive command parity error: step 1, 08/18.
// - Disconnect completes, bus freed: step 2, 28.
// - ATN during disconnect: 18, step 1 or 0.
// - Terminate completes, bus freed: step 2, 28.
// - ATN during terminate: 18, step 1 or 0.
//
// Implementation choice: the Avalon-MM interface to the registers.
`include "tssr_regs.svh"
`default_nettype none

module tssr_step_reporter
    import tssr_pkg::*;
(
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // Avalon-MM slave
    input  wire logic [5:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    // Sequence control from command decoder
    input  wire logic        i_seq_start,
    input  wire logic [2:0]  i_seq_cmd,
    input  wire logic        i_seq_stop,
    input  wire logic [2:0]  i_sel_bus_id,
    // Receive side of the SCSI transfer engine
    input  wire logic        i_rx_valid,
    input  wire logic [7:0]  i_rx_data,
    input  wire logic        i_rx_perr,
    input  wire logic        i_rx_bad_id,
    input  wire logic        i_cdb_done,
    // Send side of the SCSI transfer engine
    input  wire logic        i_byte_sent,
    // SCSI bus pin
    input  wire logic        i_scsi_atn_n,
    // FIFO write port
    output logic             o_fifo_wr,
    output logic [7:0]       o_fifo_data,
    // Sequence status
    output logic             o_busy,
    output logic             o_seq_done,
    output logic             o_bus_release,
    output logic [2:0]       o_step_code,
    output logic [7:0]       o_int_cause
);

    tssr_state_s_t s_q;
    tssr_state_s_t s_d;

    logic       atn;
    logic       req;
    logic [3:0] idx;

    // Second flop only; the first may still be settling
    assign atn = ~s_q.atn_s2;
    assign req = i_avs_read | i_avs_write;
    assign idx = i_avs_address[5:2];

    // ------------------------------------------------------------
    // Limits
    // ------------------------------------------------------------
    // No byte counting here: the transfer engine marks the end of
    // a command block, so a lost done pulse leaves the engine busy
    // until a stop pulse arrives.

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic       fin;
        logic [2:0] fcode;
        logic [7:0] fcause;
        logic [7:0] base_st;
        logic [7:0] atn_st;
        fin     = 1'b0;
        fcode   = `TSSR_STEP_RESET;
        fcause  = `TSSR_CAUSE_RESET;
        base_st = `TSSR_ST_CMD;
        atn_st  = `TSSR_CAUSE_RESET;

        // --------------------------------------------------------
        // Defaults: pulses drop, ATN pin runs through two flops
        // --------------------------------------------------------
        s_d             = s_q;
        s_d.atn_s1      = i_scsi_atn_n;
        s_d.atn_s2      = s_q.atn_s1;
        s_d.done        = 1'b0;
        s_d.release_bus = 1'b0;
        s_d.fifo_wr     = 1'b0;
        s_d.ack         = req & ~s_q.ack;

        // --------------------------------------------------------
        // Cause bits shared by the command, stop and identify-error exits
        // --------------------------------------------------------
        // Kind as started, even if the command input moves later
        case (s_q.kind)
            TSSR_CMD_SEL: begin
                base_st = `TSSR_ST_SEL;
            end
            TSSR_CMD_SEL_ATN: begin
                base_st = `TSSR_ST_SEL_ATN;
            end
            default: begin
                base_st = `TSSR_ST_CMD;
            end
        endcase
        // Synchronised ATN only; the raw pin could tear the cause
        if (atn) begin
            atn_st = `TSSR_ST_ATN;
        end

        // --------------------------------------------------------
        // Sequence engine
        // --------------------------------------------------------
        case (s_q.st)
            TSSR_IDLE: begin
                if (i_seq_start) begin
                    s_d.kind    = tssr_cmd_t'(i_seq_cmd);
                    s_d.atn_cmd = 1'b0;
                    s_d.msg_cnt = 2'h0;
                    s_d.sent    = 1'b0;
                    s_d.step    = `TSSR_STEP_FIRST;
                    s_d.base    = `TSSR_STEP_CMD_SHORT;
                    // Unused codes start nothing; engine stays idle
                    case (tssr_cmd_t'(i_seq_cmd))
                        TSSR_CMD_SEL,
                        TSSR_CMD_SEL_ATN: begin
                            s_d.st = TSSR_LOAD_ID;
                        end
                        TSSR_CMD_RCV: begin
                            s_d.st = TSSR_CMD;
                        end
                        TSSR_CMD_DISC,
                        TSSR_CMD_TERM: begin
                            s_d.st = TSSR_SEND;
                        end
                        default: begin
                            s_d.st = TSSR_IDLE;
                        end
                    endcase
                end
            end

            TSSR_LOAD_ID: begin
                s_d.fifo_wr   = 1'b1;
                s_d.fifo_data = {5'h00, i_sel_bus_id};
                if (s_q.kind == TSSR_CMD_SEL) begin
                    s_d.st = TSSR_LOAD_NULL;
                end else begin
                    s_d.st = TSSR_MSG;
                end
            end

            TSSR_LOAD_NULL: begin
                s_d.fifo_wr   = 1'b1;
                s_d.fifo_data = `TSSR_NULL_MSG;
                s_d.st        = TSSR_CMD;
            end

            // Identify byte, then two more with the option set and ATN held
            TSSR_MSG: begin
                if (i_rx_valid) begin
                    s_d.fifo_wr   = 1'b1;
                    s_d.fifo_data = i_rx_data;
                    s_d.msg_cnt   = s_q.msg_cnt + 2'h1;
                    if (s_q.msg_cnt == 2'h0) begin
                        if (i_rx_perr || i_rx_bad_id) begin
                            fin    = 1'b1;
                            fcode  = `TSSR_STEP_FIRST;
                            fcause = `TSSR_ST_SEL_ATN | atn_st;
                        end else if (atn && s_q.ext_opt) begin
                            // ATN here asks for the two extra bytes
                            s_d.step = `TSSR_STEP_FIRST;
                        end else if (atn) begin
                            fin    = 1'b1;
                            fcode  = `TSSR_STEP_FIRST;
                            fcause = `TSSR_ST_SEL_ATN | `TSSR_ST_ATN;
                        end else begin
                            s_d.st   = TSSR_CMD;
                            s_d.base = `TSSR_STEP_CMD_SHORT;
                        end
                    end else if (i_rx_perr) begin
                        fin    = 1'b1;
                        fcode  = `TSSR_STEP_EXT_MSG;
                        fcause = `TSSR_ST_SEL_ATN;
                    end else if (s_q.msg_cnt == 2'h2) begin
                        if (atn) begin
                            fin    = 1'b1;
                            fcode  = `TSSR_STEP_EXT_MSG;
                            fcause = `TSSR_ST_SEL_ATN | `TSSR_ST_ATN;
                        end else begin
                            s_d.st   = TSSR_CMD;
                            s_d.base = `TSSR_STEP_CMD_EXT;
                        end
                    end
                end
            end

            // ATN seen in command phase sticks until the exit
            TSSR_CMD: begin
                if (atn) begin
                    s_d.atn_cmd = 1'b1;
                end
                if (i_rx_valid) begin
                    s_d.fifo_wr   = 1'b1;
                    s_d.fifo_data = i_rx_data;
                    s_d.step      = s_q.base;
                    if (i_rx_perr) begin
                        fin    = 1'b1;
                        fcode  = s_q.base;
                        fcause = base_st | atn_st |
                                 (s_q.atn_cmd ? `TSSR_ST_ATN : `TSSR_CAUSE_RESET);
                    end
                end else if (i_cdb_done) begin
                    fin    = 1'b1;
                    fcode  = s_q.base + 3'h1;
                    fcause = base_st | atn_st |
                             (s_q.atn_cmd ? `TSSR_ST_ATN : `TSSR_CAUSE_RESET);
                end
            end

            // ATN looked at once per byte sent
            TSSR_SEND: begin
                if (i_byte_sent) begin
                    s_d.sent = 1'b1;
                    if (atn) begin
                        fin    = 1'b1;
                        fcode  = s_q.sent ? 3'h1 : `TSSR_STEP_FIRST;
                        fcause = `TSSR_ST_CMD | `TSSR_ST_ATN;
                    end else if (s_q.sent) begin
                        s_d.release_bus = 1'b1;
                        fin    = 1'b1;
                        fcode  = `TSSR_STEP_RELEASED;
                        fcause = `TSSR_ST_CMD | `TSSR_ST_FREE;
                    end
                end
            end

            default: begin
                s_d.st = TSSR_IDLE;
            end
        endcase

        // --------------------------------------------------------
        // Completion
        // --------------------------------------------------------
        // Early stop reports progress so far; a real exit wins
        if (i_seq_stop && s_q.st != TSSR_IDLE && !fin) begin
            fin    = 1'b1;
            fcode  = s_q.step;
            fcause = base_st | atn_st;
        end

        if (fin) begin
            s_d.code = fcode;
            s_d.cause = fcause;
            s_d.done = 1'b1;
            s_d.st   = TSSR_IDLE;
        end

        // --------------------------------------------------------
        // Register access: one wait state per request
        // --------------------------------------------------------
        // Data taken in the wait cycle, settled when released
        if (req && !s_q.ack) begin
            s_d.rdata = 32'h0000_0000;
            if (i_avs_read) begin
                case (idx)
                    `TSSR_IDX_CAUSE: begin
                        s_d.rdata = {24'h00_0000, s_q.cause};
                    end
                    `TSSR_IDX_STEP: begin
                        s_d.rdata = {29'h0000_0000, s_q.code};
                    end
                    `TSSR_IDX_CTRL: begin
                        s_d.rdata[`TSSR_CTRL_EXT_BIT]  = s_q.ext_opt;
                        s_d.rdata[`TSSR_CTRL_BUSY_BIT] = (s_q.st != TSSR_IDLE);
                    end
                    default: begin
                        s_d.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end
        // Write lands on the edge that ends the cycle with waitrequest low
        if (i_avs_write && s_q.ack && idx == `TSSR_IDX_CTRL) begin
            // Only lane 0 carries the option
            if (i_avs_byteenable[0]) begin
                s_d.ext_opt = i_avs_writedata[`TSSR_CTRL_EXT_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            // Clear all, then name the idle values
            s_q             <= '0;
            s_q.st          <= TSSR_IDLE;
            s_q.kind        <= TSSR_CMD_SEL;
            s_q.ext_opt     <= `TSSR_CTRL_RESET;
            s_q.atn_s1      <= 1'b1;
            s_q.atn_s2      <= 1'b1;
            s_q.cause       <= `TSSR_CAUSE_RESET;
            s_q.code        <= `TSSR_STEP_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_avs_readdata    = s_q.rdata;
    // Combinational, so the first request cycle stalls at once
    assign o_avs_waitrequest = req & ~s_q.ack;
    assign o_fifo_wr         = s_q.fifo_wr;
    assign o_fifo_data       = s_q.fifo_data;
    assign o_busy            = (s_q.st != TSSR_IDLE);
    assign o_seq_done        = s_q.done;
    assign o_bus_release     = s_q.release_bus;
    assign o_step_code       = s_q.code;
    assign o_int_cause       = s_q.cause;

endmodule : tssr_step_reporter

`default_nettype wire

/* hdl/tssr_regs.svh */
// Register offsets, field positions and status codes of the step reporter
`ifndef TSSR_REGS_SVH
`define TSSR_REGS_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define TSSR_IDX_CAUSE      4'h5
`define TSSR_IDX_STEP       4'h6
`define TSSR_IDX_CTRL       4'h8

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define TSSR_CTRL_EXT_BIT   0
`define TSSR_CTRL_BUSY_BIT  1
`define TSSR_CTRL_RESET     1'b0

// ------------------------------------------------------------
// Interrupt cause codes
// ------------------------------------------------------------
`define TSSR_ST_SEL         8'h01
`define TSSR_ST_SEL_ATN     8'h02
`define TSSR_ST_CMD         8'h08
`define TSSR_ST_ATN         8'h10
`define TSSR_ST_FREE        8'h20
`define TSSR_CAUSE_RESET    8'h00

// ------------------------------------------------------------
// Step codes
// ------------------------------------------------------------
`define TSSR_STEP_FIRST     3'h0
`define TSSR_STEP_CMD_SHORT 3'h1
`define TSSR_STEP_EXT_MSG   3'h4
`define TSSR_STEP_CMD_EXT   3'h5
`define TSSR_STEP_RELEASED  3'h2
`define TSSR_STEP_RESET     3'h0

// ------------------------------------------------------------
// FIFO contents
// ------------------------------------------------------------
`define TSSR_NULL_MSG       8'h00

`endif

/* hdl/tssr_pkg.sv */
// Types shared by the target sequence step reporter
`default_nettype none

package tssr_pkg;

    // Sequence commands accepted on the start strobe
    typedef enum logic [2:0] {
        TSSR_CMD_SEL,
        TSSR_CMD_SEL_ATN,
        TSSR_CMD_RCV,
        TSSR_CMD_DISC,
        TSSR_CMD_TERM
    } tssr_cmd_t;

    typedef enum logic [2:0] {
        TSSR_IDLE,
        TSSR_LOAD_ID,
        TSSR_LOAD_NULL,
        TSSR_MSG,
        TSSR_CMD,
        TSSR_SEND
    } tssr_state_t;

    typedef struct packed {
        tssr_state_t st;
        tssr_cmd_t   kind;
        logic        ext_opt;
        logic        atn_s1;
        logic        atn_s2;
        logic [2:0]  step;
        logic [2:0]  base;
        logic [1:0]  msg_cnt;
        logic        sent;
        logic        atn_cmd;
        logic [7:0]  cause;
        logic [2:0]  code;
        logic        done;
        logic        release_bus;
        logic        fifo_wr;
        logic [7:0]  fifo_data;
        logic        ack;
        logic [31:0] rdata;
    } tssr_state_s_t;

endpackage : tssr_pkg

`default_nettype wire

/* verif/tssr_chk.sv */
// Port assertions for the step reporter
`default_nettype none
module tssr_chk
    import tssr_pkg::*;
(
    input wire logic        i_sys_clk,
    input wire logic        i_rst,
    input wire logic [5:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic        i_seq_start,
    input wire logic [2:0]  i_seq_cmd,
    input wire logic [2:0]  i_sel_bus_id,
    input wire logic        o_fifo_wr,
    input wire logic [7:0]  o_fifo_data,
    input wire logic        o_busy,
    input wire logic        o_seq_done,
    input wire logic        o_bus_release,
    input wire logic [2:0]  o_step_code,
    input wire logic [7:0]  o_int_cause
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    chk_pair_same_cycle: assert property (
        ($changed(o_step_code) || $changed(o_int_cause)) |-> o_seq_done)
        else $error("step or cause moved without done");
    chk_done_idle: assert property (
        o_seq_done |-> !o_busy) else $error("done while busy");
    chk_free_pair: assert property (
        o_bus_release |-> o_seq_done && o_step_code == 3'h2 && o_int_cause == 8'h28)
        else $error("release without step 2 cause 28");
    chk_free_only: assert property (
        o_seq_done && o_int_cause == 8'h28 |-> o_bus_release)
        else $error("cause 28 without release");
    chk_cause_legal: assert property (
        o_seq_done |-> o_int_cause inside {8'h01, 8'h11, 8'h02, 8'h12, 8'h08, 8'h18, 8'h28})
        else $error("illegal cause code");
    chk_short_steps: assert property (
        o_seq_done && o_int_cause[3:0] != 4'h2 |-> o_step_code <= 3'h2)
        else $error("step above 2 outside extended select");
    chk_sel_loads: assert property (
        i_seq_start && !o_busy && i_seq_cmd == 3'h0 |-> ##[1:3]
        (o_fifo_wr && o_fifo_data == {5'h00, i_sel_bus_id}) ##1
        (o_fifo_wr && o_fifo_data == 8'h00)) else $error("bus id and null not loaded");
    chk_read_cause: assert property (
        i_avs_read && !o_avs_waitrequest && i_avs_address[5:2] == 4'h5
        |-> o_avs_readdata == {24'h000000, o_int_cause}) else $error("cause read wrong");
    chk_read_step: assert property (
        i_avs_read && !o_avs_waitrequest && i_avs_address[5:2] == 4'h6
        |-> o_avs_readdata == {29'h0, o_step_code}) else $error("step read wrong");
endmodule : tssr_chk

bind tssr_step_reporter tssr_chk i_tssr_chk (.*);
`default_nettype wire

/* verif/tssr_init_model.sv */
// Initiator stand-in driving the receive and send strobes
`default_nettype none
module tssr_init_model (
    input  wire logic      i_sys_clk,
    output var logic       o_rx_valid,
    output var logic [7:0] o_rx_data,
    output var logic       o_rx_perr,
    output var logic       o_rx_bad_id,
    output var logic       o_cdb_done,
    output var logic       o_byte_sent,
    output var logic       o_atn_n
);
    initial begin
        {o_rx_valid, o_rx_perr, o_rx_bad_id, o_cdb_done, o_byte_sent} = 5'h00;
        o_rx_data = 8'hA5;
        o_atn_n = 1'b1;
    end
    // Idle gap after each pulse; stale data shown inverted
    task automatic put(input logic [7:0] d, input logic pe, input logic bad);
        o_rx_valid  <= 1'b1;
        o_rx_data   <= d;
        o_rx_perr   <= pe;
        o_rx_bad_id <= bad;
        @(posedge i_sys_clk);
        o_rx_valid  <= 1'b0;
        o_rx_data   <= ~d;
        o_rx_perr   <= 1'b0;
        o_rx_bad_id <= 1'b0;
        @(posedge i_sys_clk);
    endtask : put
    task automatic strobe(input logic cdb);
        o_cdb_done  <= cdb;
        o_byte_sent <= ~cdb;
        @(posedge i_sys_clk);
        o_cdb_done  <= 1'b0;
        o_byte_sent <= 1'b0;
        @(posedge i_sys_clk);
    endtask : strobe
    // Extra cycle covers the two-stage synchroniser
    task automatic atn(input logic on);
        o_atn_n <= ~on;
        repeat (3) @(posedge i_sys_clk);
    endtask : atn
endmodule : tssr_init_model
`default_nettype wire

/* verif/test_tssr_step_reporter.sv */
// Self-checking bench for the step reporter
`default_nettype none
module test_tssr_step_reporter
    import tssr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_sys_clk, i_rst, i_avs_read, i_avs_write, i_seq_start, i_seq_stop;
    logic [5:0]  i_avs_address;
    logic [31:0] i_avs_writedata, o_avs_readdata, rd;
    logic [3:0]  i_avs_byteenable;
    logic [2:0]  i_seq_cmd, i_sel_bus_id, o_step_code;
    logic        i_rx_valid, i_rx_perr, i_rx_bad_id, i_cdb_done, i_byte_sent, i_scsi_atn_n;
    logic [7:0]  i_rx_data, o_fifo_data, o_int_cause;
    logic        o_avs_waitrequest, o_fifo_wr, o_busy, o_seq_done, o_bus_release;
    logic [7:0]  fifo_q[$];
    int          fails = 0, compares = 0, cyc = 0;

    tssr_step_reporter i_tssr_step_reporter (.*);
    tssr_init_model i_tssr_init_model (.i_sys_clk, .o_rx_valid(i_rx_valid),
        .o_rx_data(i_rx_data), .o_rx_perr(i_rx_perr), .o_rx_bad_id(i_rx_bad_id),
        .o_cdb_done(i_cdb_done), .o_byte_sent(i_byte_sent), .o_atn_n(i_scsi_atn_n));

    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (o_fifo_wr === 1'b1) fifo_q.push_back(o_fifo_data);
        if (cyc == 20000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
        i_avs_address   <= a;
        i_avs_writedata <= wd;
        i_avs_write     <= wr;
        i_avs_read      <= ~wr;
        do @(posedge i_sys_clk); while (o_avs_waitrequest !== 1'b0);
        rd = o_avs_readdata;
        i_avs_read  <= 1'b0;
        i_avs_write <= 1'b0;
        @(posedge i_sys_clk);
    endtask : bus
    task automatic start(input logic [2:0] c);
        fifo_q.delete();
        i_seq_cmd   <= c;
        i_seq_start <= 1'b1;
        @(posedge i_sys_clk);
        i_seq_start <= 1'b0;
        @(posedge i_sys_clk);
    endtask : start
    task automatic fin(input logic [2:0] s, input logic [7:0] c, input logic rel);
        int n;
        n = 0;
        while (o_seq_done !== 1'b1 && n < 60) begin
            @(posedge i_sys_clk);
            n++;
        end
        check(o_seq_done, 1'b1);
        check(o_step_code, s);
        check(o_int_cause, c);
        check(o_bus_release, rel);
        bus(1'b0, 6'h14, 32'h0);
        check(rd, c);
        bus(1'b0, 6'h18, 32'h0);
        check(rd, s);
    endtask : fin

    task automatic t_regs();
        bus(1'b0, 6'h20, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, 6'h14, 32'hFF);
        bus(1'b0, 6'h14, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, 6'h3C, 32'h0);
        check(rd, 32'h0);
        i_avs_byteenable <= 4'hE;
        bus(1'b1, 6'h20, 32'hFFFF_FFFF);
        i_avs_byteenable <= 4'h1;
        bus(1'b0, 6'h23, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, 6'h21, 32'hFFFF_FF01);
        bus(1'b0, 6'h20, 32'h0);
        check(rd, 32'h1);
        bus(1'b1, 6'h20, 32'h0);
        start(3'h7);
        check(o_busy, 1'b0);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_receive();
        start(3'h2);
        i_tssr_init_model.put(8'h12, 1'b0, 1'b0);
        i_tssr_init_model.strobe(1'b1);
        fin(3'h2, 8'h08, 1'b0);
        i_tssr_init_model.atn(1'b1);
        start(3'h2);
        i_tssr_init_model.put(8'h34, 1'b1, 1'b0);
        fin(3'h1, 8'h18, 1'b0);
        i_tssr_init_model.atn(1'b0);
        $display("t_receive done");
    endtask : t_receive
    task automatic t_select();
        start(3'h0);
        repeat (2) @(posedge i_sys_clk);
        i_seq_stop <= 1'b1;
        @(posedge i_sys_clk);
        i_seq_stop <= 1'b0;
        fin(3'h0, 8'h01, 1'b0);
        check(fifo_q.size(), 32'd2);
        check({16'h0, fifo_q[0], fifo_q[1]}, {16'h0, 8'h05, 8'h00});
        i_sel_bus_id <= 3'h2;
        start(3'h0);
        repeat (2) @(posedge i_sys_clk);
        i_tssr_init_model.put(8'h28, 1'b0, 1'b0);
        i_tssr_init_model.atn(1'b1);
        i_tssr_init_model.strobe(1'b1);
        fin(3'h2, 8'h11, 1'b0);
        check({16'h0, fifo_q[0], fifo_q[2]}, {16'h0, 8'h02, 8'h28});
        start(3'h0);
        check(o_busy, 1'b1);
        bus(1'b0, 6'h20, 32'h0);
        check(rd, 32'h2);
        i_tssr_init_model.put(8'h29, 1'b1, 1'b0);
        fin(3'h1, 8'h11, 1'b0);
        i_tssr_init_model.atn(1'b0);
        $display("t_select done");
    endtask : t_select
    task automatic t_select_atn();
        i_tssr_init_model.atn(1'b1);
        start(3'h1);
        i_tssr_init_model.put(8'h80, 1'b0, 1'b0);
        fin(3'h0, 8'h12, 1'b0);
        i_tssr_init_model.atn(1'b0);
        start(3'h1);
        i_tssr_init_model.put(8'hC0, 1'b0, 1'b1);
        fin(3'h0, 8'h02, 1'b0);
        start(3'h1);
        i_tssr_init_model.put(8'h80, 1'b0, 1'b0);
        i_tssr_init_model.put(8'h12, 1'b0, 1'b0);
        i_tssr_init_model.strobe(1'b1);
        fin(3'h2, 8'h02, 1'b0);
        $display("t_select_atn done");
    endtask : t_select_atn
    task automatic t_extended();
        bus(1'b1, 6'h20, 32'h1);
        i_tssr_init_model.atn(1'b1);
        start(3'h1);
        i_tssr_init_model.put(8'h80, 1'b0, 1'b0);
        i_tssr_init_model.put(8'h20, 1'b0, 1'b0);
        i_tssr_init_model.atn(1'b0);
        i_tssr_init_model.put(8'h07, 1'b0, 1'b0);
        i_tssr_init_model.put(8'h12, 1'b0, 1'b0);
        i_tssr_init_model.strobe(1'b1);
        fin(3'h6, 8'h02, 1'b0);
        i_tssr_init_model.atn(1'b1);
        start(3'h1);
        i_tssr_init_model.put(8'h80, 1'b0, 1'b0);
        i_tssr_init_model.put(8'h20, 1'b1, 1'b0);
        fin(3'h4, 8'h02, 1'b0);
        start(3'h1);
        repeat (3) i_tssr_init_model.put(8'h80, 1'b0, 1'b0);
        fin(3'h4, 8'h12, 1'b0);
        start(3'h1);
        repeat (2) i_tssr_init_model.put(8'h80, 1'b0, 1'b0);
        i_tssr_init_model.atn(1'b0);
        i_tssr_init_model.put(8'h07, 1'b0, 1'b0);
        i_tssr_init_model.put(8'h55, 1'b1, 1'b0);
        fin(3'h5, 8'h02, 1'b0);
        start(3'h1);
        i_tssr_init_model.put(8'h80, 1'b0, 1'b0);
        i_tssr_init_model.strobe(1'b1);
        fin(3'h2, 8'h02, 1'b0);
        start(3'h1);
        i_tssr_init_model.put(8'h80, 1'b0, 1'b0);
        i_tssr_init_model.put(8'h55, 1'b1, 1'b0);
        fin(3'h1, 8'h02, 1'b0);
        bus(1'b1, 6'h20, 32'h0);
        $display("t_extended done");
    endtask : t_extended
    task automatic t_release();
        start(3'h3);
        repeat (2) i_tssr_init_model.strobe(1'b0);
        fin(3'h2, 8'h28, 1'b1);
        start(3'h3);
        i_tssr_init_model.strobe(1'b0);
        i_tssr_init_model.atn(1'b1);
        i_tssr_init_model.strobe(1'b0);
        fin(3'h1, 8'h18, 1'b0);
        start(3'h4);
        i_tssr_init_model.strobe(1'b0);
        fin(3'h0, 8'h18, 1'b0);
        i_tssr_init_model.atn(1'b0);
        start(3'h4);
        repeat (2) i_tssr_init_model.strobe(1'b0);
        fin(3'h2, 8'h28, 1'b1);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        @(posedge i_sys_clk);
        bus(1'b0, 6'h14, 32'h0);
        check(rd, 32'h0);
        $display("t_release done");
    endtask : t_release
    task automatic wrap_up();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up

    initial begin
        {i_rst, i_avs_read, i_avs_write, i_seq_start, i_seq_stop} = 5'h10;
        {i_avs_address, i_avs_writedata, i_seq_cmd} = '0;
        i_avs_byteenable = 4'hF;
        i_sel_bus_id = 3'h5;
        repeat (4) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        @(posedge i_sys_clk);
        t_regs();
        t_receive();
        t_select();
        t_select_atn();
        t_extended();
        t_release();
        wrap_up();
    end
endmodule : test_tssr_step_reporter
`default_nettype wire
